//--- dpw_window_intr.v
// two-port window interrupt, vector handshake and power-fail logic
// Function
// - Each port can interrupt for an access error or for a message from the other side.
// - The request is raised only on the top priority line br7.
// - An error is flagged when an access could not pass or the target bus is in power fail.
// - With intr_enable_bit set and a fault or message pending, the port requests the bus.
// - The internal request passes a priority select before it drives br7.
// - The arbiter answers with bg7 and the port acknowledges it with sack.
// - When the previous master frees the bus the port drops sack and raises bbsy and intr.
// - While the port is in state DPW_ST_VEC, read_path_select puts mux input 6 (vector) on the data lines.
// - On ssyn the port releases intr, bbsy and data and returns to idle.
// - The logic is duplicated for both buses with mirrored behaviour.
// - A window supply failure asserts ac lo and dc lo on both buses.
// - Ac lo on one bus shows as peer_power_warn, bit 13 of the other port's control register.
// - A peer power warning interrupts the observing port when intr_enable_bit is set.
// - A window access while the target bus has ac lo fails as an access error.
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "dpw_defines.vh"
module dpw_window_intr (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst,
    // avalon-mm slave
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // interrupt to local software
    output reg         irq,
    // priority select per port, 1 routes to br7
    input  wire [1:0]  prio_sel_br7,
    // window access attempts from each side (index = originating port)
    input  wire [1:0]  win_access_try,
    input  wire [1:0]  win_access_nopass,
    // per-port bus handshake, index 0 = bus a, 1 = bus b
    input  wire [1:0]  bus_bg7,
    input  wire [1:0]  bus_bbsy_in,
    input  wire [1:0]  bus_ssyn,
    input  wire [1:0]  bus_ac_lo,
    output reg  [1:0]  bus_br7,
    output reg  [1:0]  bus_sack,
    output reg  [1:0]  bus_bbsy,
    output reg  [1:0]  bus_intr,
    output reg  [15:0] bus_data_a,
    output reg  [15:0] bus_data_b,
    output reg  [1:0]  bus_data_oe_n,
    output reg  [5:0]  read_path_select,
    // power fail clamps
    input  wire        supply_fail,
    output reg  [1:0]  drv_ac_lo,
    output reg  [1:0]  drv_dc_lo
);

    // ****************************************************************
    // register storage
    // ****************************************************************
    // map, byte offsets:
    //   0x0 port a control, 0x4 port b control
    //     bit 6 intr_enable_bit, bit 7 message (set from the peer's word,
    //     cleared by a one in the own word), bit 8 vector lsb on read,
    //     bit 13 peer_power_warn (read only), bit 15 window_access_fault
    //     (written zero clears it), bits 23:16 vector on write
    //   0x8 event status, write one to clear
    //     bit 0/1 vector handed over on port a/b, bit 2/3 peer warning rose
    //   0xC event mask, same layout
    // per-port enable, message and fault flags
    reg  [1:0]  ie;
    reg  [1:0]  msg;
    reg  [1:0]  fault;
    // vector address words, lower byte only
    reg  [7:0]  vec_a;
    reg  [7:0]  vec_b;
    // sticky events, their mask and the one-cycle set pulses
    reg  [3:0]  evt;
    reg  [3:0]  evt_mask;
    reg  [3:0]  evt_set;
    // peer power warning as seen by each port
    reg  [1:0]  warn;

    // two-flop synchronisers for asynchronous bus inputs
    reg  [1:0]  bg_s1, bg_s2, ssyn_s1, ssyn_s2, bbsy_s1, bbsy_s2, ac_s1, ac_s2;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bg_s1   <= 2'h0;
            bg_s2   <= 2'h0;
            ssyn_s1 <= 2'h0;
            ssyn_s2 <= 2'h0;
            bbsy_s1 <= 2'h0;
            bbsy_s2 <= 2'h0;
            ac_s1   <= 2'h0;
            ac_s2   <= 2'h0;
        end else begin
            // first stage may go metastable; only the second stage is read
            bg_s1   <= bus_bg7;
            bg_s2   <= bg_s1;
            ssyn_s1 <= bus_ssyn;
            ssyn_s2 <= ssyn_s1;
            // bus busy from the previous master, seen two edges late
            bbsy_s1 <= bus_bbsy_in;
            bbsy_s2 <= bbsy_s1;
            // peer power warning, level only
            ac_s1   <= bus_ac_lo;
            ac_s2   <= ac_s1;
        end
    end

    // ****************************************************************
    // bus slave
    // ****************************************************************
    // a write lands on the edge where the master sees waitrequest low,
    // so the master and the registers agree on the one cycle that counts
    wire        wr_hit = avs_write & ~avs_waitrequest;
    // control fields live in the low half word
    wire [15:0] wd     = avs_writedata[15:0];

    // one wait cycle: each access is answered on the second edge;
    // readdata is loaded on the first edge and stands in the answer cycle,
    // which costs a cycle per access but keeps the read mux off the bus path
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            if ((avs_read | avs_write) & avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
            end else begin
                avs_waitrequest <= 1'b1;
            end
            // read word of the addressed register
            case (avs_address)
                `DPW_REG_CTRL_A: avs_readdata <= {16'h0000, fault[0], 1'b0, warn[0], 4'h0,
                                                  vec_a[0], msg[0], ie[0], 6'h00};
                `DPW_REG_CTRL_B: avs_readdata <= {16'h0000, fault[1], 1'b0, warn[1], 4'h0,
                                                  vec_b[0], msg[1], ie[1], 6'h00};
                `DPW_REG_STAT:   avs_readdata <= {28'h0000000, evt};
                `DPW_REG_MASK:   avs_readdata <= {28'h0000000, evt_mask};
                default:         avs_readdata <= 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    // ****************************************************************
    // per-port control, causes and handshake
    // ****************************************************************
    // one copy per bus; index 0 is bus a, index 1 bus b. a port asks for
    // the bus only while its enable is set and a cause is pending, so a
    // cause that clears early withdraws the request before the grant.
    // the peer index 1-p gives the mirrored view of the other bus.
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_port
            // handshake state of this port
            reg  [1:0] st;
            wire       peer_ac  = ac_s2[1-p];
            wire [7:0] vec      = (p == 0) ? vec_a : vec_b;
            wire       ctl_wr   = wr_hit & (avs_address == ((p == 0) ? `DPW_REG_CTRL_A
                                                                      : `DPW_REG_CTRL_B));
            // a cause arriving while software clears it is kept
            wire       new_flt  = win_access_try[p] & (win_access_nopass[p] | peer_ac);
            wire       pend     = ie[p] & (fault[p] | msg[p] | warn[p]);
            // enable, fault, warning and message flags of this port
            always @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    ie[p]    <= 1'b0;
                    fault[p] <= 1'b0;
                    warn[p]  <= 1'b0;
                    msg[p]   <= 1'b0;
                end else begin
                    warn[p] <= peer_ac;
                    if (ctl_wr) ie[p] <= wd[`DPW_CTRL_IE];
                    if (new_flt) fault[p] <= 1'b1;
                    else if (ctl_wr & ~wd[`DPW_CTRL_FAULT]) fault[p] <= 1'b0;
                    if (wr_hit & (avs_address == ((p == 0) ? `DPW_REG_CTRL_B
                                                           : `DPW_REG_CTRL_A))
                        & wd[`DPW_CTRL_MSG]) msg[p] <= 1'b1;
                    else if (ctl_wr & wd[`DPW_CTRL_MSG]) msg[p] <= 1'b0;
                end
            end
            // request, grant, acknowledge, vector phase
            always @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    st                           <= `DPW_ST_IDLE;
                    bus_br7[p]                   <= 1'b0;
                    bus_sack[p]                  <= 1'b0;
                    bus_bbsy[p]                  <= 1'b0;
                    bus_intr[p]                  <= 1'b0;
                    // data lines released: output enable high
                    bus_data_oe_n[p]             <= 1'b1;
                    read_path_select[3*p+2 -: 3] <= `DPW_MUX_IDLE;
                    evt_set[p]                   <= 1'b0;
                end else begin
                    // done pulse lasts one cycle
                    evt_set[p] <= 1'b0;
                    case (st)
                        `DPW_ST_IDLE: begin
                            // request only through the priority select
                            bus_br7[p] <= pend & prio_sel_br7[p];
                            if (pend & prio_sel_br7[p]) st <= `DPW_ST_REQ;
                        end
                        `DPW_ST_REQ: begin
                            // cause gone before the grant: withdraw quietly
                            if (~pend) begin
                                bus_br7[p] <= 1'b0;
                                st         <= `DPW_ST_IDLE;
                            end else if (bg_s2[p]) begin
                                // grant seen: drop the request, acknowledge
                                bus_br7[p]  <= 1'b0;
                                bus_sack[p] <= 1'b1;
                                st          <= `DPW_ST_ACK;
                            end
                        end
                        `DPW_ST_ACK: begin
                            // wait for the previous master to let go of busy
                            if (~bbsy_s2[p]) begin
                                bus_sack[p]                  <= 1'b0;
                                bus_bbsy[p]                  <= 1'b1;
                                bus_intr[p]                  <= 1'b1;
                                read_path_select[3*p+2 -: 3] <= `DPW_MUX_VEC;
                                bus_data_oe_n[p]             <= 1'b0;
                                st                           <= `DPW_ST_VEC;
                            end
                        end
                        `DPW_ST_VEC: begin
                            // vector taken: release everything at once
                            if (ssyn_s2[p]) begin
                                bus_bbsy[p] <= 1'b0;
                                bus_intr[p] <= 1'b0;
                                bus_data_oe_n[p] <= 1'b1;
                                read_path_select[3*p+2 -: 3] <= `DPW_MUX_IDLE;
                                evt_set[p] <= 1'b1;
                                st <= `DPW_ST_IDLE;
                            end
                        end
                        default: st <= `DPW_ST_IDLE;
                    endcase
                end
            end
            // vector onto the data lines; each port owns its own word so
            // that no register has two writers
            if (p == 0) begin : g_data_a
                // loaded while waiting for busy, held through the vector phase
                always @(posedge ref_clk or posedge rst) begin
                    if (rst) begin
                        bus_data_a <= 16'h0000;
                    end else begin
                        bus_data_a <= (st == `DPW_ST_ACK) ? {8'h00, vec} :
                                      ((st == `DPW_ST_VEC) ? bus_data_a : 16'h0000);
                    end
                end
            end else begin : g_data_b
                // mirror of port a on the second bus
                always @(posedge ref_clk or posedge rst) begin
                    if (rst) begin
                        bus_data_b <= 16'h0000;
                    end else begin
                        bus_data_b <= (st == `DPW_ST_ACK) ? {8'h00, vec} :
                                      ((st == `DPW_ST_VEC) ? bus_data_b : 16'h0000);
                    end
                end
            end
            // warning rising edge is an event; warn resets low like the
            // idle level of the pin, so no false edge follows reset
            always @(posedge ref_clk or posedge rst) begin
                if (rst) evt_set[p+2] <= 1'b0;
                else     evt_set[p+2] <= peer_ac & ~warn[p];
            end
        end
    endgenerate

    // ****************************************************************
    // vector registers, status, mask, interrupt, power fail
    // ****************************************************************
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            vec_a     <= `DPW_VEC_RST;
            vec_b     <= `DPW_VEC_RST;
            evt       <= `DPW_EVT_RST;
            evt_mask  <= `DPW_EVT_RST;
            irq       <= 1'b0;
            drv_ac_lo <= 2'h0;
            drv_dc_lo <= 2'h0;
        end else begin
            // vector is taken from bits 23:16 of the avalon write data
            if (wr_hit & (avs_address == `DPW_REG_CTRL_A)) vec_a <= avs_writedata[23:16];
            if (wr_hit & (avs_address == `DPW_REG_CTRL_B)) vec_b <= avs_writedata[23:16];
            if (wr_hit & (avs_address == `DPW_REG_MASK)) evt_mask <= avs_writedata[3:0];
            // set wins over write-one-to-clear
            if (wr_hit & (avs_address == `DPW_REG_STAT))
                evt <= (evt & ~avs_writedata[3:0]) | evt_set;
            else
                evt <= evt | evt_set;
            // level output from a flop: one cycle behind the status
            irq <= |(evt & evt_mask);
            // clamps follow the supply one cycle later on both buses
            drv_ac_lo <= {2{supply_fail}};
            drv_dc_lo <= {2{supply_fail}};
        end
    end

endmodule // dpw_window_intr

//--- dpw_defines.vh
// constants for the two-port window interrupt and power-fail block
`ifndef DPW_DEFINES_VH
`define DPW_DEFINES_VH
// register byte offsets
`define DPW_REG_CTRL_A     4'h0
`define DPW_REG_CTRL_B     4'h4
`define DPW_REG_STAT       4'h8
`define DPW_REG_MASK       4'hC
// control register fields (per port)
`define DPW_CTRL_IE        6
`define DPW_CTRL_MSG       7
`define DPW_CTRL_FAULT     15
`define DPW_CTRL_WARN      13
`define DPW_CTRL_RST       16'h0000
// status bits: 0/1 port a/b vector done, 2/3 port a/b peer power warn
`define DPW_EVT_W          4
`define DPW_EVT_RST        4'h0
// vector address reset value
`define DPW_VEC_RST        8'h00
// multiplexer input that carries the vector
`define DPW_MUX_VEC        3'h6
`define DPW_MUX_IDLE       3'h0
// handshake states
`define DPW_ST_IDLE        2'h0
`define DPW_ST_REQ         2'h1
`define DPW_ST_ACK         2'h2
`define DPW_ST_VEC         2'h3
`endif

//--- dpw_bus_model.sv
// processor and arbiter model for one attached bus
`timescale 1ns/1ps
module dpw_bus_model #(parameter int DLY = 2) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // port side of the bus
    input  wire logic br7,
    input  wire logic sack,
    input  wire logic intr,
    output logic      bg7,
    output logic      bbsy_in,
    output logic      ssyn
);
    int cnt;
    // grant, hold the previous master a while, answer the vector; DLY sets prompt or slow
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bg7 <= 1'b0;
            bbsy_in <= 1'b0;
            ssyn <= 1'b0;
            cnt <= 0;
        end else begin
            cnt <= (br7 | sack | intr) ? cnt + 1 : 0;
            bg7 <= br7 & ~sack & (cnt > DLY);
            if (bg7)
                bbsy_in <= 1'b1;
            else if (sack && cnt > 4 * DLY)
                bbsy_in <= 1'b0;
            ssyn <= intr & ((cnt > 6 * DLY) | ssyn);
        end
    end
endmodule // dpw_bus_model

//--- dpw_window_intr_checker.sv
// port assertions for the window interrupt block
`timescale 1ns/1ps
module dpw_window_intr_checker (
    // clock and reset
    input wire        ref_clk,
    input wire        rst,
    // watched ports
    input wire [1:0]  prio_sel_br7,
    input wire [1:0]  bus_bg7,
    input wire [1:0]  bus_ssyn,
    input wire [1:0]  bus_br7,
    input wire [1:0]  bus_sack,
    input wire [1:0]  bus_bbsy,
    input wire [1:0]  bus_intr,
    input wire [1:0]  bus_data_oe_n,
    input wire [5:0]  read_path_select,
    input wire        supply_fail,
    input wire [1:0]  drv_ac_lo,
    input wire [1:0]  drv_dc_lo
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // steps of the vector handshake; grant must be seen long enough to pass the synchroniser
    sequence s_grant_a; (bus_bg7[0] && bus_br7[0]) [*4]; endsequence
    sequence s_ssyn_a; $rose(bus_ssyn[0]) && bus_intr[0]; endsequence
    a_grant_ack: assert property (s_grant_a |-> ##[0:3] bus_sack[0])
        else $error("grant not acknowledged");
    a_ssyn_release: assert property (s_ssyn_a |-> ##[1:6] (!bus_intr[0] && bus_data_oe_n[0]))
        else $error("vector phase not released");
    a_vec_sel_a: assert property (read_path_select[2:0] == (bus_bbsy[0] ? 3'h6 : 3'h0))
        else $error("port a select wrong");
    a_vec_sel_b: assert property (read_path_select[5:3] == (bus_bbsy[1] ? 3'h6 : 3'h0))
        else $error("port b select wrong");
    a_sack_excl: assert property ((bus_sack & bus_bbsy) == 2'b00)
        else $error("sack with bbsy");
    a_intr_bbsy: assert property (bus_intr == bus_bbsy)
        else $error("intr and bbsy differ");
    a_prio_gate: assert property (!prio_sel_br7[0] && !$past(prio_sel_br7[0]) |-> !bus_br7[0])
        else $error("br7 without select");
    a_pf_clamp: assert property (1'b1 |=> drv_ac_lo == {2{$past(supply_fail)}} && drv_dc_lo == drv_ac_lo)
        else $error("clamps do not follow supply");
endmodule // dpw_window_intr_checker
bind dpw_window_intr dpw_window_intr_checker chk_u (.ref_clk, .rst, .prio_sel_br7, .bus_bg7,
    .bus_ssyn, .bus_br7, .bus_sack, .bus_bbsy, .bus_intr, .bus_data_oe_n, .read_path_select,
    .supply_fail, .drv_ac_lo, .drv_dc_lo);

//--- dpw_tb.sv
// self-checking bench for the window interrupt block
`timescale 1ns/1ps
`include "dpw_defines.vh"
module testbench;
    logic        ref_clk, rst, avs_read, avs_write, avs_waitrequest, irq, supply_fail;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [1:0]  prio_sel_br7, win_access_try, win_access_nopass, bus_ac_lo, bus_data_oe_n;
    logic [1:0]  bus_br7, bus_sack, bus_bbsy, bus_intr, drv_ac_lo, drv_dc_lo;
    wire  [1:0]  bus_bg7, bus_bbsy_in, bus_ssyn;
    logic [15:0] bus_data_a, bus_data_b;
    logic [5:0]  read_path_select;
    logic [7:0]  vec;
    int          bad_count = 0, n_compared = 0, seed = 28, i;
    dpw_window_intr dut_u (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .irq, .prio_sel_br7, .win_access_try, .win_access_nopass,
        .bus_bg7, .bus_bbsy_in, .bus_ssyn, .bus_ac_lo, .bus_br7, .bus_sack, .bus_bbsy, .bus_intr,
        .bus_data_a, .bus_data_b, .bus_data_oe_n, .read_path_select, .supply_fail, .drv_ac_lo,
        .drv_dc_lo);
    // slow far side on bus a, prompt one on bus b
    dpw_bus_model #(.DLY(6)) bus_a_u (.ref_clk, .rst, .br7(bus_br7[0]), .sack(bus_sack[0]),
        .intr(bus_intr[0]), .bg7(bus_bg7[0]), .bbsy_in(bus_bbsy_in[0]), .ssyn(bus_ssyn[0]));
    dpw_bus_model #(.DLY(1)) bus_b_u (.ref_clk, .rst, .br7(bus_br7[1]), .sack(bus_sack[1]),
        .intr(bus_intr[1]), .bg7(bus_bg7[1]), .bbsy_in(bus_bbsy_in[1]), .ssyn(bus_ssyn[1]));
    // ****************
    // bus tasks
    // ****************
    task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wait_intr(input int p);
        for (i = 0; i < 400 && bus_intr[p] !== 1'b1; i++) @(posedge ref_clk);
    endtask
    task automatic wait_idle(input int p);
        for (i = 0; i < 400 && (bus_br7[p] | bus_sack[p] | bus_intr[p]) !== 1'b0; i++)
            @(posedge ref_clk);
        repeat (10) @(posedge ref_clk);
        chk("idle", {bus_br7[p], bus_sack[p], bus_intr[p]}, 0);
    endtask
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // clock and watchdog; the run needs well under 4000 cycles
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #100000;
        bad_count++;
        conclude();
    end
    // main sequence
    initial begin
        {rst, avs_read, avs_write, supply_fail} = 4'b1000;
        {avs_address, avs_writedata} = 36'h0;
        {prio_sel_br7, win_access_try, win_access_nopass, bus_ac_lo} = 8'h00;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        chk("oe_rst", bus_data_oe_n, 2'b11);
        av_xfer(1, `DPW_REG_MASK, 32'hF);
        for (int p = 0; p < 2; p++) begin
            vec = 8'($random(seed));
            av_xfer(1, p ? `DPW_REG_CTRL_B : `DPW_REG_CTRL_A, {8'h00, vec, 16'h0040});
            av_xfer(1, p ? `DPW_REG_CTRL_A : `DPW_REG_CTRL_B, 32'h80);
            repeat (20) @(posedge ref_clk);
            chk("br7_gated", bus_br7[p], 0);
            prio_sel_br7[p] <= 1'b1;
            wait_intr(p);
            chk("intr", bus_intr[p], 1);
            chk("vector", p ? bus_data_b[7:0] : bus_data_a[7:0], vec);
            chk("oe", bus_data_oe_n[p], 0);
            av_xfer(1, p ? `DPW_REG_CTRL_B : `DPW_REG_CTRL_A, {8'h00, vec, 16'h00C0});
            wait_idle(p);
            av_xfer(0, `DPW_REG_STAT, 0);
            chk("done_evt", rd[p], 1);
            chk("irq_on", irq, 1);
            av_xfer(1, `DPW_REG_STAT, 32'h1 << p);
            // status clears at the answer edge, irq follows one edge later
            repeat (2) @(posedge ref_clk);
            chk("irq_off", irq, 0);
            $display("port %0d message test done", p);
        end
        win_access_try <= 2'b01;
        win_access_nopass <= 2'b01;
        @(posedge ref_clk);
        {win_access_try, win_access_nopass} <= 4'h0;
        av_xfer(0, `DPW_REG_CTRL_A, 0);
        chk("fault", rd[15], 1);
        av_xfer(1, `DPW_REG_CTRL_A, 0);
        bus_ac_lo <= 2'b10;
        repeat (4) @(posedge ref_clk);
        win_access_try <= 2'b01;
        @(posedge ref_clk);
        win_access_try <= 2'b00;
        av_xfer(0, `DPW_REG_CTRL_A, 0);
        chk("pf_fault", rd[15], 1);
        chk("warn", rd[13], 1);
        av_xfer(0, `DPW_REG_STAT, 0);
        chk("warn_evt", rd[2], 1);
        av_xfer(1, `DPW_REG_CTRL_A, 32'h40);
        wait_intr(0);
        chk("warn_intr", bus_intr[0], 1);
        bus_ac_lo <= 2'b00;
        av_xfer(1, `DPW_REG_CTRL_A, 0);
        av_xfer(1, `DPW_REG_STAT, 32'hF);
        wait_idle(0);
        $display("power warning test done");
        av_xfer(0, 4'h2, 0);
        chk("unmapped", rd, 0);
        supply_fail <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("clamp", {drv_ac_lo, drv_dc_lo}, 4'hF);
        $display("clamp test done");
        conclude();
    end
endmodule // testbench
